// File: core/plc_classify.sv
`timescale 1ns/1ps
module plc_classify
  import plc_pkg::*;
(
  input wire plc_op_e i_op,
  output logic o_priv,
  output logic o_flush,
  output logic o_psw_write
);
  always_comb begin
    o_priv = 1'b0;
    o_psw_write = 1'b0;
    case (i_op)
      OP_HALT, OP_LP_HALT, OP_EXT_RESET, OP_PRIV_OTHER: begin
        o_priv = 1'b1;
      end
      OP_MOVE_PSW, OP_AND_PSW, OP_XOR_PSW, OP_OR_PSW, OP_RTE: begin
        o_priv = 1'b1;
        o_psw_write = 1'b1;
      end
      default: begin
        o_priv = 1'b0;
      end
    endcase
    o_flush = o_priv | (i_op == OP_TRAP) | (i_op == OP_FLAGS);
  end
endmodule

// File: core/plc_core.sv
`timescale 1ns/1ps
// How it works
// - exception handling runs supervisor, supervisor bus references, supervisor stack
// - halt, low-power halt and external reset refused in user state
// - any instruction that can change the supervisor bit is privileged
// - trap instruction enters exception handling with its own vector number
// - supervisor bit clear means user state and user address space codes
// - in user state stack pointer and register seven mean user stack
// - user to supervisor only through exception entry
// - push old state word first, then set supervisor bit
// - leave supervisor only by state word writes or return, in supervisor
// - after state word writes flush pipeline, refill from new space
// - short frames restore state word and program counter only
// - bus or address error frames restore full processor state
// - trapping and flag instructions flush the pipeline, privileged ones only in supervisor state
module plc_core
  import plc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_instr_valid,
  input wire plc_op_e i_instr_op,
  input wire logic [3:0] i_trap_num,
  input wire logic [15:0] i_psw_operand,
  input wire logic i_exc_req,
  input wire logic [7:0] i_exc_vector,
  input wire logic i_push_done,
  input wire logic i_exc_done,
  input wire logic [15:0] i_rte_psw,
  input wire logic i_rte_full,
  input wire logic i_prog_ref,
  output logic o_super_ff,
  output logic [15:0] o_psw_ff,
  output logic [2:0] o_fc_ff,
  output logic o_sp_super_ff,
  output logic o_exec_ok_ff,
  output logic o_flush_ff,
  output logic o_push_req_ff,
  output logic [15:0] o_saved_psw_ff,
  output logic o_exc_busy_ff,
  output logic [7:0] o_exc_vector_ff,
  output logic o_restore_full_ff,
  output logic o_restore_short_ff
);
  // ****************************************************
  // classification
  // ****************************************************
  logic priv;
  logic flush_op;
  logic psw_write;
  plc_classify u_classify (
    .i_op(i_instr_op),
    .o_priv(priv),
    .o_flush(flush_op),
    .o_psw_write(psw_write)
  );

  // ****************************************************
  // state machine
  // ****************************************************
  plc_state_e state_ff, nxt_state;
  logic [15:0] nxt_psw;
  logic [15:0] nxt_saved_psw;
  logic [7:0] nxt_vector;
  logic nxt_exec_ok;
  logic nxt_flush;
  logic nxt_push_req;
  logic nxt_busy;
  logic nxt_full;
  logic nxt_short;
  logic nxt_sup_ref;
  logic [2:0] nxt_fc;
  logic s_now;

  assign s_now = o_psw_ff[PSW_S_POS];

  always_comb begin
    nxt_state = state_ff;
    nxt_psw = o_psw_ff;
    nxt_saved_psw = o_saved_psw_ff;
    nxt_vector = o_exc_vector_ff;
    nxt_exec_ok = 1'b0;
    nxt_flush = 1'b0;
    nxt_push_req = 1'b0;
    nxt_full = 1'b0;
    nxt_short = 1'b0;
    case (state_ff)
      ST_RUN: begin
        if (i_exc_req) begin
          nxt_state = ST_PUSH;
          nxt_vector = i_exc_vector;
          nxt_saved_psw = o_psw_ff;
          nxt_push_req = 1'b1;
        end else if (i_instr_valid && priv && !s_now) begin
          nxt_state = ST_PUSH;
          nxt_vector = VEC_PRIV;
          nxt_saved_psw = o_psw_ff;
          nxt_push_req = 1'b1;
        end else if (i_instr_valid && i_instr_op == OP_TRAP) begin
          nxt_state = ST_PUSH;
          nxt_vector = VEC_TRAP_BASE + {4'h0, i_trap_num};
          nxt_saved_psw = o_psw_ff;
          nxt_push_req = 1'b1;
          nxt_flush = 1'b1;
        end else if (i_instr_valid && i_instr_op != OP_NONE) begin
          nxt_exec_ok = 1'b1;
          nxt_flush = flush_op;
          if (psw_write) begin
            // only reached in supervisor, so s may drop here alone
            case (i_instr_op)
              OP_MOVE_PSW: nxt_psw = i_psw_operand;
              OP_AND_PSW: nxt_psw = o_psw_ff & i_psw_operand;
              OP_XOR_PSW: nxt_psw = o_psw_ff ^ i_psw_operand;
              OP_OR_PSW: nxt_psw = o_psw_ff | i_psw_operand;
              OP_RTE: begin
                nxt_psw = i_rte_psw;
                nxt_full = i_rte_full;
                nxt_short = !i_rte_full;
              end
              default: nxt_psw = o_psw_ff;
            endcase
          end
        end
      end
      ST_PUSH: begin
        nxt_push_req = !i_push_done;
        if (i_push_done) begin
          nxt_psw[PSW_S_POS] = 1'b1;
          nxt_state = ST_EXC;
        end
      end
      ST_EXC: begin
        if (i_exc_done) begin
          nxt_state = ST_RUN;
          nxt_flush = 1'b1; // handler stream starts fresh
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
    // whole exception sequence counts as supervisor, even before s is set
    nxt_busy = (nxt_state != ST_RUN);
    nxt_sup_ref = nxt_psw[PSW_S_POS] | nxt_busy;
    if (nxt_sup_ref) begin
      nxt_fc = i_prog_ref ? FC_SUP_PROG : FC_SUP_DATA;
    end else begin
      nxt_fc = i_prog_ref ? FC_USER_PROG : FC_USER_DATA;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= ST_RUN;
      o_psw_ff <= PSW_RST;
      o_super_ff <= PSW_RST[PSW_S_POS];
      o_fc_ff <= FC_SUP_PROG;
      o_sp_super_ff <= 1'b1;
      o_exec_ok_ff <= 1'b0;
      o_flush_ff <= 1'b0;
      o_push_req_ff <= 1'b0;
      o_saved_psw_ff <= 16'h0000;
      o_exc_busy_ff <= 1'b0;
      o_exc_vector_ff <= 8'h00;
      o_restore_full_ff <= 1'b0;
      o_restore_short_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      o_psw_ff <= nxt_psw;
      o_super_ff <= nxt_psw[PSW_S_POS];
      o_fc_ff <= nxt_fc;
      o_sp_super_ff <= nxt_sup_ref;
      o_exec_ok_ff <= nxt_exec_ok;
      o_flush_ff <= nxt_flush;
      o_push_req_ff <= nxt_push_req;
      o_saved_psw_ff <= nxt_saved_psw;
      o_exc_busy_ff <= nxt_busy;
      o_exc_vector_ff <= nxt_vector;
      o_restore_full_ff <= nxt_full;
      o_restore_short_ff <= nxt_short;
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  logic run_idle;
  assign run_idle = (state_ff == ST_RUN) && !i_exc_req && i_instr_valid;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_exc_super_refs: assert property (
    o_exc_busy_ff |-> o_sp_super_ff && o_fc_ff[2])
    else $error("exception sequence not supervisor");
  a_user_priv_block: assert property (
    run_idle && priv && !s_now |=> !o_exec_ok_ff && o_push_req_ff
      && o_exc_vector_ff == VEC_PRIV)
    else $error("privileged op ran in user state");
  a_s_rise_exc: assert property (
    $rose(o_super_ff) |-> $past(state_ff == ST_PUSH && i_push_done))
    else $error("supervisor entered outside exception");
  a_push_before_s: assert property (
    (state_ff == ST_RUN) ##1 (state_ff == ST_PUSH) |->
      o_saved_psw_ff == $past(o_psw_ff) && o_push_req_ff
      && o_super_ff == $past(o_super_ff))
    else $error("state word not saved before s set");
  a_user_space: assert property (
    !o_super_ff && !o_exc_busy_ff |-> !o_fc_ff[2] && !o_sp_super_ff)
    else $error("user state drives supervisor space");
  a_trap_vector: assert property (
    run_idle && i_instr_op == OP_TRAP && (priv == 1'b0) |=>
      o_exc_vector_ff == VEC_TRAP_BASE + {4'h0, $past(i_trap_num)}
      ##0 o_flush_ff)
    else $error("trap vector wrong");
  a_flush_after_psw: assert property (
    run_idle && s_now && flush_op && i_instr_op != OP_TRAP |=>
      o_flush_ff ##0 o_exec_ok_ff)
    else $error("pipeline not flushed");
  a_rte_restore: assert property (
    run_idle && s_now && i_instr_op == OP_RTE |=>
      o_psw_ff == $past(i_rte_psw)
      && o_restore_full_ff == $past(i_rte_full)
      && o_restore_short_ff == !$past(i_rte_full))
    else $error("return restore wrong");
  a_exc_exit_bound: assert property (
    o_restore_full_ff |-> !o_restore_short_ff && o_exec_ok_ff
      && $past(i_rte_full) && o_psw_ff == $past(i_rte_psw))
    else $error("full restore wrong");

  c_priv_violation: cover property (
    run_idle && priv && !s_now ##1 o_push_req_ff ##[1:20] o_exc_busy_ff);
  c_rte_to_user: cover property (
    run_idle && i_instr_op == OP_RTE ##1 !o_super_ff);
  c_trap_entry: cover property (
    run_idle && i_instr_op == OP_TRAP && !s_now ##[1:20] o_super_ff);
endmodule

// File: core/plc_pkg.sv
package plc_pkg;
  // ****************************************************
  // processor state word layout
  // ****************************************************
  localparam int PSW_W = 16;
  localparam int PSW_S_POS = 13;
  localparam logic [15:0] PSW_RST = 16'h2700;
  // ****************************************************
  // exception vectors
  // ****************************************************
  localparam logic [7:0] VEC_PRIV = 8'h08;
  localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
  // ****************************************************
  // address space codes
  // ****************************************************
  localparam logic [2:0] FC_USER_DATA = 3'h1;
  localparam logic [2:0] FC_USER_PROG = 3'h2;
  localparam logic [2:0] FC_SUP_DATA = 3'h5;
  localparam logic [2:0] FC_SUP_PROG = 3'h6;
  // ****************************************************
  // instruction classes and states
  // ****************************************************
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_OTHER = 4'b0001,
    OP_HALT = 4'b0010,
    OP_LP_HALT = 4'b0011,
    OP_EXT_RESET = 4'b0100,
    OP_MOVE_PSW = 4'b0101,
    OP_AND_PSW = 4'b0110,
    OP_XOR_PSW = 4'b0111,
    OP_OR_PSW = 4'b1000,
    OP_RTE = 4'b1001,
    OP_TRAP = 4'b1010,
    OP_FLAGS = 4'b1011,
    OP_PRIV_OTHER = 4'b1100
  } plc_op_e;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_PUSH = 2'b01,
    ST_EXC = 2'b10
  } plc_state_e;
endpackage

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import plc_pkg::*;
  typedef struct {
    plc_op_e op;
    logic [15:0] opnd;
    logic [15:0] psw;
    logic fl;
  } plc_row_s;
  logic i_clk, i_rst_b, i_instr_valid, i_exc_req, i_push_done, i_exc_done;
  logic i_rte_full, i_prog_ref;
  plc_op_e i_instr_op;
  logic [3:0] i_trap_num;
  logic [15:0] i_psw_operand, i_rte_psw, o_psw_ff, o_saved_psw_ff;
  logic [7:0] i_exc_vector, o_exc_vector_ff;
  logic o_super_ff, o_sp_super_ff, o_exec_ok_ff, o_flush_ff, o_push_req_ff;
  logic o_exc_busy_ff, o_restore_full_ff, o_restore_short_ff;
  logic [2:0] o_fc_ff;
  logic [7:0] vec;
  int n_mismatch = 0;
  int cmp_count = 0;
  // ****************************************************
  // supervisor cases: op, operand, state word after, flush
  // ****************************************************
  plc_row_s rows[10] = '{
    '{OP_OR_PSW, 16'h0015, 16'h2715, 1'b1},
    '{OP_XOR_PSW, 16'h0005, 16'h2710, 1'b1},
    '{OP_AND_PSW, 16'hfff0, 16'h2710, 1'b1},
    '{OP_MOVE_PSW, 16'h2300, 16'h2300, 1'b1},
    '{OP_FLAGS, 16'h2300, 16'h2300, 1'b1},
    '{OP_HALT, 16'h2300, 16'h2300, 1'b1},
    '{OP_LP_HALT, 16'h2300, 16'h2300, 1'b1},
    '{OP_EXT_RESET, 16'h2300, 16'h2300, 1'b1},
    '{OP_PRIV_OTHER, 16'h2300, 16'h2300, 1'b1},
    '{OP_OTHER, 16'h2300, 16'h2300, 1'b0}};
  // user-state attempts; last one is an external request
  plc_op_e uops[11] = '{OP_HALT, OP_LP_HALT, OP_EXT_RESET, OP_MOVE_PSW,
    OP_AND_PSW, OP_XOR_PSW, OP_OR_PSW, OP_RTE, OP_PRIV_OTHER, OP_TRAP,
    OP_OTHER};
  plc_core dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_instr_valid(i_instr_valid), .i_instr_op(i_instr_op),
    .i_trap_num(i_trap_num), .i_psw_operand(i_psw_operand),
    .i_exc_req(i_exc_req), .i_exc_vector(i_exc_vector),
    .i_push_done(i_push_done), .i_exc_done(i_exc_done),
    .i_rte_psw(i_rte_psw), .i_rte_full(i_rte_full), .i_prog_ref(i_prog_ref),
    .o_super_ff(o_super_ff), .o_psw_ff(o_psw_ff), .o_fc_ff(o_fc_ff),
    .o_sp_super_ff(o_sp_super_ff), .o_exec_ok_ff(o_exec_ok_ff),
    .o_flush_ff(o_flush_ff), .o_push_req_ff(o_push_req_ff),
    .o_saved_psw_ff(o_saved_psw_ff), .o_exc_busy_ff(o_exc_busy_ff),
    .o_exc_vector_ff(o_exc_vector_ff),
    .o_restore_full_ff(o_restore_full_ff),
    .o_restore_short_ff(o_restore_short_ff));
  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [2:0] fc_exp(input logic s);
    if (s) begin
      return i_prog_ref ? FC_SUP_PROG : FC_SUP_DATA;
    end
    return i_prog_ref ? FC_USER_PROG : FC_USER_DATA;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // inputs change at the falling edge; outputs read at the next falling edge
  task automatic issue(input plc_op_e op, input logic [15:0] opnd);
    i_instr_op = op;
    i_psw_operand = opnd;
    i_instr_valid = 1'b1;
    @(negedge i_clk);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ****************************************************
  // sequence
  // ****************************************************
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    #2000000;
    n_mismatch++;
    close_out();
  end
  initial begin
    {i_instr_valid, i_exc_req, i_push_done, i_exc_done, i_rte_full} = '0;
    i_prog_ref = 1'b1;
    i_instr_op = OP_NONE;
    i_trap_num = 4'h7;
    i_psw_operand = 16'h0000;
    i_rte_psw = 16'h0300;
    i_exc_vector = 8'h40;
    i_rst_b = 1'b0;
    repeat (2) @(negedge i_clk);
    chk(o_psw_ff, PSW_RST);
    chk(o_fc_ff, FC_SUP_PROG);
    i_rst_b = 1'b1;
    @(negedge i_clk);
    foreach (rows[k]) begin
      i_prog_ref = k[0];
      issue(rows[k].op, rows[k].opnd);
      chk(o_psw_ff, rows[k].psw);
      chk(o_exec_ok_ff, 1'b1);
      chk(o_flush_ff, rows[k].fl);
      chk(o_fc_ff, fc_exp(1'b1));
    end
    issue(OP_MOVE_PSW, 16'h0300);
    chk(o_super_ff, 1'b0);
    chk(o_flush_ff, 1'b1);
    // a supervisor bit left set here would leak the supervisor stack
    for (int k = 0; k < 11; k++) begin
      vec = (k < 9) ? VEC_PRIV : (k == 9) ? VEC_TRAP_BASE + 8'h07 : 8'h40;
      chk(o_fc_ff, fc_exp(1'b0));
      chk(o_sp_super_ff, 1'b0);
      i_prog_ref = k[0];
      i_exc_req = (k == 10);
      issue(uops[k], 16'h2700);
      i_exc_req = 1'b0;
      chk(o_exc_vector_ff, vec);
      chk(o_exec_ok_ff, 1'b0);
      chk(o_flush_ff, k == 9);
      chk(o_push_req_ff, 1'b1);
      chk(o_saved_psw_ff, 16'h0300);
      chk(o_super_ff, 1'b0);
      chk(o_fc_ff, fc_exp(1'b1));
      chk(o_sp_super_ff, 1'b1);
      i_push_done = 1'b1;
      issue(OP_OTHER, 16'h0000);
      i_push_done = 1'b0;
      chk(o_super_ff, 1'b1);
      chk(o_exec_ok_ff, 1'b0);
      chk(o_exc_busy_ff, 1'b1);
      i_exc_done = 1'b1;
      @(negedge i_clk);
      i_exc_done = 1'b0;
      chk(o_exc_busy_ff, 1'b0);
      chk(o_flush_ff, 1'b1);
      i_rte_full = k[0];
      issue(OP_RTE, 16'h0000);
      chk(o_restore_full_ff, k[0]);
      chk(o_restore_short_ff, !k[0]);
      chk(o_psw_ff, 16'h0300);
      chk(o_flush_ff, 1'b1);
      chk(o_fc_ff, fc_exp(1'b0));
    end
    close_out();
  end
endmodule
